// ===== pkg/sfu_pkg.sv
package sfu_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int SFU_UNITS = 2;
    localparam int SFU_DW = 32;
    localparam int SFU_AW = 8;

    // ------------------------------------------------------------------
    // Register map (byte offsets inside one unit window)
    // ------------------------------------------------------------------
    localparam logic [3:0] SFU_CTRL_OFS = 4'h0;
    localparam logic [3:0] SFU_OPA_OFS = 4'h4;
    localparam logic [3:0] SFU_OPB_OFS = 4'h8;
    localparam logic [3:0] SFU_RES_OFS = 4'hc;
    localparam int SFU_UNIT_SEL_BIT = 4;
    localparam int SFU_WIN_TOP = 7;
    localparam int SFU_WIN_LSB = 5;

    // ------------------------------------------------------------------
    // Control field layout
    // ------------------------------------------------------------------
    localparam int SFU_APPLY_BIT = 0;
    localparam int SFU_MODE_LSB = 4;
    localparam int SFU_MODE_W = 3;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [31:0] SFU_OPERAND_RST = 32'h0000_0000;
    localparam logic [31:0] SFU_RESULT_RST = 32'h0000_0000;
    localparam logic [31:0] SFU_TRUE = 32'h0000_0001;
    localparam logic [31:0] SFU_FALSE = 32'h0000_0000;
    localparam logic SFU_APPLY_RST = 1'b0;
    localparam logic [1:0] SFU_RESP_OKAY = 2'b00;
    localparam logic [1:0] SFU_RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SFU_OP_SWITCH = 3'b000,
        SFU_OP_LOGIC_NOT = 3'b001,
        SFU_OP_AND = 3'b010,
        SFU_OP_OR = 3'b011,
        SFU_OP_NEGATE = 3'b100,
        SFU_OP_MAGNITUDE = 3'b101,
        SFU_OP_COMPARE = 3'b110
    } sfu_mode_t;

    localparam sfu_mode_t SFU_MODE_RST = SFU_OP_SWITCH;

    // Operands are signed hundredths of a percent
    typedef struct packed {
        logic apply;
        sfu_mode_t mode;
        logic [31:0] opa;
        logic [31:0] opb;
    } sfu_cfg_t;

endpackage : sfu_pkg

// ===== sim/sfu_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus handshake and result checks
// ------------------------------------------------------------
module sfu_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0][31:0] unit_result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_b_blocks: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_r_blocks: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken twice");
    chk_b_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    chk_r_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_unmapped: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_wr_refused: assert property (
        s_axi_awvalid && s_axi_awready && (s_axi_awaddr[7:5] != 3'h0
        || s_axi_awaddr[3:0] == 4'hc) |-> ##[1:20]
        (s_axi_bvalid && s_axi_bresp == 2'h2)) else $error("bad write accepted");
    chk_res_cause: assert property (
        $changed(unit_result) |-> $past(s_axi_bvalid))
        else $error("result moved without a write");
    chk_res_reset: assert property (
        $rose(rstn) |-> unit_result == 64'h0) else $error("result not cleared");
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_refuse: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : sfu_checker

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [1:0][31:0] unit_result;
    logic [1:0] qb[$];
    logic [33:0] qr[$];
    int fails = 0, tests_run = 0, cyc = 0;

    sfu_top sfu_top_i (
        .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .unit_result(unit_result)
    );

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task test_done;
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    initial forever #12.5 sys_clk = ~sys_clk;

    // Whole run is about 900 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    // Responses are judged where they are taken
    always @(posedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, {qb.pop_front(), 32'h0});
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, qr.pop_front());
    end

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        qb.push_back(er);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge sys_clk);
            if (s_axi_awready && !aw) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Late ready makes the response wait and hold
        repeat ($urandom_range(2)) @(posedge sys_clk);
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [33:0] e);
        qr.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat ($urandom_range(2)) @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    function automatic logic [31:0] ref_fn(logic ap, logic [2:0] m,
        logic signed [31:0] a, logic signed [31:0] b);
        if (!ap)
            return a;
        case (m)
            3'h0: return b;
            3'h1: return {31'h0, a == 32'h0};
            3'h2: return {31'h0, a != 32'h0 && b != 32'h0};
            3'h3: return {31'h0, a != 32'h0 || b != 32'h0};
            3'h4: return -a;
            3'h5: return a < 0 ? -a : a;
            3'h6: return {31'h0, a > b};
            default: return a;
        endcase
    endfunction : ref_fn

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] a, b, e;
        logic [31:0] last [2];
        logic [7:0] base;
        last = '{32'h0, 32'h0};
        void'($urandom(16));
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (int r = 0; r < 8; r++)
            rd(8'((r % 4) * 4 + (r / 4) * 16), '0);
        // Every code, both flag values, both units, with zero and ties
        for (int i = 0; i < 64; i++) begin
            a = $urandom_range(6553600) - 3276800;
            b = (i % 6 == 0) ? a : $urandom_range(6553600) - 3276800;
            if (i % 5 == 0)
                a = 32'h0;
            if (i % 6 == 3)
                b = 32'h0;
            if (i == 22 || i == 26) begin
                a = 32'hffce_0000;
                b = 32'h0032_0000;
            end
            base = {3'h0, i[0], 4'h0};
            wr(base + 8'h4, a, 2'h0);
            wr(base + 8'h8, b, 2'h0);
            wr(base, {25'h0, i[4:2], 3'h0, i[1]}, 2'h0);
            e = ref_fn(i[1], i[4:2], a, b);
            last[i[0]] = e;
            rd(base + 8'hc, {2'h0, e});
            check({2'h0, unit_result[i[0]]}, {2'h0, e});
            check({2'h0, unit_result[!i[0]]}, {2'h0, last[!i[0]]});
        end
        // Result is read-only, holes are refused
        wr(8'h0c, 32'h0000_1234, sfu_pkg::SFU_RESP_SLVERR);
        wr(8'h20, 32'h0000_0001, sfu_pkg::SFU_RESP_SLVERR);
        rd(8'h24, {sfu_pkg::SFU_RESP_SLVERR, 32'h0});
        rd(8'h0c, {2'h0, last[0]});
        repeat (2) @(posedge sys_clk);
        test_done();
    end
endmodule : tb

bind sfu_top sfu_checker sfu_checker_i (
    .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .unit_result(unit_result)
);

// ===== src/sfu_top.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module sfu_unit #(
    parameter logic UNIT_SEL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic wr_unit,
    input wire logic [3:0] wr_ofs,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_strb,
    output sfu_pkg::sfu_cfg_t cfg,
    output logic [31:0] result
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] sfu_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return m;
    endfunction : sfu_merge

    function automatic logic [31:0] sfu_eval(input sfu_pkg::sfu_cfg_t c);
        logic [31:0] r;
        logic a_true;
        logic b_true;
        r = c.opa;
        a_true = (c.opa != 32'h0000_0000);
        b_true = (c.opb != 32'h0000_0000);
        if (c.apply) begin
            case (c.mode)
                sfu_pkg::SFU_OP_SWITCH: begin
                    r = c.opb;
                end
                sfu_pkg::SFU_OP_LOGIC_NOT: begin
                    r = a_true ? sfu_pkg::SFU_FALSE : sfu_pkg::SFU_TRUE;
                end
                sfu_pkg::SFU_OP_AND: begin
                    r = (a_true && b_true) ? sfu_pkg::SFU_TRUE
                                           : sfu_pkg::SFU_FALSE;
                end
                sfu_pkg::SFU_OP_OR: begin
                    r = (a_true || b_true) ? sfu_pkg::SFU_TRUE
                                           : sfu_pkg::SFU_FALSE;
                end
                sfu_pkg::SFU_OP_NEGATE: begin
                    r = 32'h0000_0000 - c.opa;
                end
                sfu_pkg::SFU_OP_MAGNITUDE: begin
                    r = c.opa[31] ? (32'h0000_0000 - c.opa) : c.opa;
                end
                sfu_pkg::SFU_OP_COMPARE: begin
                    // Equal operands give false
                    r = ($signed(c.opa) > $signed(c.opb))
                        ? sfu_pkg::SFU_TRUE : sfu_pkg::SFU_FALSE;
                end
                default: begin
                    // Unused code seven behaves as pass-through
                    r = c.opa;
                end
            endcase
        end
        return r;
    endfunction : sfu_eval

    // ------------------------------------------------------------------
    // Unit state
    // ------------------------------------------------------------------
    sfu_pkg::sfu_cfg_t cfg_r;
    logic [31:0] result_r;
    logic hit;

    // Only the addressed unit takes the write
    assign hit = wr_en && (wr_unit == UNIT_SEL);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg_r.apply <= sfu_pkg::SFU_APPLY_RST;
            cfg_r.mode <= sfu_pkg::SFU_MODE_RST;
            cfg_r.opa <= sfu_pkg::SFU_OPERAND_RST;
            cfg_r.opb <= sfu_pkg::SFU_OPERAND_RST;
        end else if (hit) begin
            case (wr_ofs)
                sfu_pkg::SFU_CTRL_OFS: begin
                    // Control moves only when its low byte is enabled
                    if (wr_strb[0]) begin
                        cfg_r.apply <= wr_data[sfu_pkg::SFU_APPLY_BIT];
                        cfg_r.mode <= sfu_pkg::sfu_mode_t'(
                            wr_data[sfu_pkg::SFU_MODE_LSB +:
                                    sfu_pkg::SFU_MODE_W]);
                    end
                end
                sfu_pkg::SFU_OPA_OFS: begin
                    // Full 32-bit word covers the signed span
                    cfg_r.opa <= sfu_merge(cfg_r.opa, wr_data,
                                           wr_strb);
                end
                sfu_pkg::SFU_OPB_OFS: begin
                    cfg_r.opb <= sfu_merge(cfg_r.opb, wr_data,
                                           wr_strb);
                end
                default: begin
                    cfg_r <= cfg_r;
                end
            endcase
        end
    end

    // Registered result costs one cycle but keeps outputs glitch free
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result_r <= sfu_pkg::SFU_RESULT_RST;
        end else begin
            result_r <= sfu_eval(cfg_r);
        end
    end

    // Top reads config back over the bus
    assign cfg = cfg_r;
    assign result = result_r;

endmodule : sfu_unit

module sfu_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0][31:0] unit_result
);

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic awready_r;
    logic wready_r;
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_fire;
    logic wr_ok;
    logic wr_unit;
    logic [3:0] wr_ofs;

    assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_unit = aw_addr_r[sfu_pkg::SFU_UNIT_SEL_BIT];
    assign wr_ofs = aw_addr_r[3:0];
    // Result word is read-only, so writing it is refused
    assign wr_ok = (aw_addr_r[sfu_pkg::SFU_WIN_TOP:sfu_pkg::SFU_WIN_LSB]
                    == 3'h0)
                   && (wr_ofs == sfu_pkg::SFU_CTRL_OFS
                       || wr_ofs == sfu_pkg::SFU_OPA_OFS
                       || wr_ofs == sfu_pkg::SFU_OPB_OFS);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= sfu_pkg::SFU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? sfu_pkg::SFU_RESP_OKAY
                                 : sfu_pkg::SFU_RESP_SLVERR;
            end
            // Ready returns only after the response, one write at a time
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Unit state
    // ------------------------------------------------------------------
    sfu_pkg::sfu_cfg_t cfg_r [sfu_pkg::SFU_UNITS];
    logic [31:0] result_r [sfu_pkg::SFU_UNITS];
    logic wr_commit;

    // Refused writes never reach a unit
    assign wr_commit = wr_fire && wr_ok;

    // One instance per unit keeps the two fully apart
    for (genvar g = 0; g < sfu_pkg::SFU_UNITS; g++) begin : gen_unit
        sfu_unit #(
            .UNIT_SEL(1'(g))
        ) sfu_unit_i (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .wr_en(wr_commit),
            .wr_unit(wr_unit),
            .wr_ofs(wr_ofs),
            .wr_data(w_data_r),
            .wr_strb(w_strb_r),
            .cfg(cfg_r[g]),
            .result(result_r[g])
        );
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_value;
    logic rd_ok;
    logic rd_unit;

    assign rd_unit = s_axi_araddr[sfu_pkg::SFU_UNIT_SEL_BIT];

    always_comb begin
        rd_value = 32'h0000_0000;
        rd_ok = 1'b0;
        if (s_axi_araddr[sfu_pkg::SFU_WIN_TOP:sfu_pkg::SFU_WIN_LSB]
            == 3'h0) begin
            rd_ok = 1'b1;
            case (s_axi_araddr[3:0])
                sfu_pkg::SFU_CTRL_OFS: begin
                    rd_value[sfu_pkg::SFU_APPLY_BIT] = cfg_r[rd_unit].apply;
                    rd_value[sfu_pkg::SFU_MODE_LSB +: sfu_pkg::SFU_MODE_W] =
                        cfg_r[rd_unit].mode;
                end
                sfu_pkg::SFU_OPA_OFS: begin
                    rd_value = cfg_r[rd_unit].opa;
                end
                sfu_pkg::SFU_OPB_OFS: begin
                    rd_value = cfg_r[rd_unit].opb;
                end
                sfu_pkg::SFU_RES_OFS: begin
                    rd_value = result_r[rd_unit];
                end
                default: begin
                    rd_ok = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= sfu_pkg::SFU_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_value;
                rresp_r <= rd_ok ? sfu_pkg::SFU_RESP_OKAY
                                 : sfu_pkg::SFU_RESP_SLVERR;
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign unit_result[0] = result_r[0];
    assign unit_result[1] = result_r[1];

endmodule : sfu_top
